// ### fieldbus_io_defs.svh
// object indices, field codes, reset values and timing for the fieldbus i/o image
`ifndef FIELDBUS_IO_DEFS_SVH
`define FIELDBUS_IO_DEFS_SVH

`define OBJ_OUT_MAP       16'h1600
`define OBJ_IN_MAP        16'h1A00
`define OBJ_STAT_MAP      16'h1A01
`define OBJ_FB_MODE       16'h2100
`define OBJ_FB_PATTERN    16'h2102
`define OBJ_FACTORY       16'h2F00
`define OBJ_IN_BYTE       16'h4000
`define OBJ_DIAG_WORD     16'h4001
`define OBJ_OUT_BYTE      16'h5000

`define SUB_COUNT         8'h00
`define SUB_ENTRY         8'h01
`define MAP_LEN_BYTE      8'h08
`define MAP_LEN_WORD      8'h20
`define ENTRIES_ONE       8'h01
`define ENTRIES_TWO       8'h02

`define LINK_INIT         4'h1
`define LINK_PREOP        4'h2
`define LINK_BOOT         4'h3
`define LINK_SAFEOP       4'h4
`define LINK_OP           4'h8

`define FB_LOW            8'h00
`define FB_HIGH           8'h01
`define FB_HOLD           8'h02
`define FB_PATTERN        8'h03
`define FB_MODE_RESET     8'h00
`define FB_PATTERN_RESET  8'h00

`define FACTORY_NORMAL    8'h00
`define FACTORY_RESTORE   8'h01

`define DIAG_OUT_SHORT    0
`define DIAG_OUT_SURGE    1
`define DIAG_ACT_SHORT    2
`define DIAG_ACT_UV       3
`define DIAG_SENS_SURGE   4
`define DIAG_SENS_UV      5

`define CLK_FREQ_HZ       50000000
`define WDOG_TIME_MS      100

`endif

// ### fieldbus_io_pkg.sv
// types shared by the fieldbus i/o image block
package fieldbus_io_pkg;
  typedef enum logic [1:0] {ARB_IDLE, ARB_MBX, ARB_PDO} arbState_t;
  typedef logic [15:0] objIndex_t;
  typedef logic [7:0]  objByte_t;
endpackage

// ### output_fallback_select.sv
// selects the safe-state output value from the fallback mode
`timescale 1ns/1ps
`include "fieldbus_io_defs.svh"
module output_fallback_select #(
  parameter int OUT_COUNT = 4
)(
  input  wire logic [7:0]           mode,
  input  wire logic [7:0]           pattern,
  input  wire logic [OUT_COUNT-1:0] lastOut,
  output wire logic [OUT_COUNT-1:0] fallback
);
  wire logic isHigh;
  wire logic isHold;
  wire logic isPattern;

  assign isHigh    = mode == `FB_HIGH;
  assign isHold    = mode == `FB_HOLD;
  assign isPattern = mode == `FB_PATTERN;

  // pattern only counts in pattern mode; low is the default
  assign fallback = isPattern ? pattern[OUT_COUNT-1:0] :
                    isHold    ? lastOut :
                    isHigh    ? {OUT_COUNT{1'b1}} :
                                {OUT_COUNT{1'b0}};
endmodule

// ### fieldbus_io_safe_state_image.sv
// object image, link supervision and safe-state output logic of the i/o slave
`timescale 1ns/1ps
`include "fieldbus_io_defs.svh"
module fieldbus_io_safe_state_image
  import fieldbus_io_pkg::*;
#(
  parameter int OUT_COUNT   = 4,
  parameter int WDOG_CYCLES = `WDOG_TIME_MS * (`CLK_FREQ_HZ / 1000)
)(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 mbxReqValid,
  input  wire logic                 mbxReqWrite,
  input  wire logic [15:0]          mbxIndex,
  input  wire logic [7:0]           mbxSubindex,
  input  wire logic [31:0]          mbxWrData,
  output logic                      mbxBusy,
  output logic                      mbxAck,
  output logic                      mbxAbort,
  output logic [31:0]               mbxRdData,
  input  wire logic                 pdoReqValid,
  input  wire logic [7:0]           pdoOutData,
  output logic                      pdoBusy,
  output logic                      pdoDone,
  output logic [7:0]                pdoInByte,
  output logic [31:0]               pdoStatusWord,
  input  wire logic                 linkReqValid,
  input  wire logic [3:0]           linkReqState,
  output logic [3:0]                linkState,
  output logic                      linkReqError,
  output logic                      commFault,
  input  wire logic                 deviceRestart,
  output logic                      factoryApplied,
  input  wire logic [7:0]           digitalIn,
  input  wire logic                 sensorUnderVolt,
  input  wire logic                 sensorSurge,
  input  wire logic                 actuatorUnderVolt,
  input  wire logic                 actuatorShort,
  input  wire logic                 outputSurge,
  input  wire logic                 outputShort,
  output logic [OUT_COUNT-1:0]      digitalOut
);
  localparam int WDOG_W = $clog2(WDOG_CYCLES + 1);

  if (OUT_COUNT < 1 || OUT_COUNT > 8 || WDOG_CYCLES < 2) begin : g_bad_params
    $error("output count must be 1..8 and watchdog at least 2 cycles");
  end

  arbState_t            arbState_q;
  arbState_t            arbState_d;
  logic                 mbxPend_q;
  logic                 mbxWr_q;
  objIndex_t            mbxIdx_q;
  objByte_t             mbxSub_q;
  logic [31:0]          mbxData_q;
  logic                 pdoPend_q;
  logic [7:0]           pdoData_q;
  logic [3:0]           linkState_q;
  logic                 linkReqError_q;
  logic                 commFault_q;
  logic [WDOG_W-1:0]    wdogCnt_q;
  objByte_t             fbMode_q;
  objByte_t             fbPat_q;
  objByte_t             facReq_q;
  logic                 factoryApplied_q;
  logic [OUT_COUNT-1:0] outImage_q;
  logic [OUT_COUNT-1:0] digitalOut_q;
  logic [7:0]           inImage_q;
  logic [31:0]          statImage_q;
  logic                 mbxAck_q;
  logic                 mbxAbort_q;
  logic [31:0]          mbxRdData_q;
  logic                 pdoDone_q;
  logic [7:0]           pdoInByte_q;
  logic [31:0]          pdoStatusWord_q;
  logic [32:0]          rdResult;

  // mailbox sub-entry lookup shared by every mapped object
  function automatic logic [32:0] subWord(input objByte_t sub, input objByte_t cnt,
                                          input logic [31:0] entry);
    if (sub == `SUB_COUNT) begin
      subWord = {1'b1, 24'h000000, cnt};
    end else if (sub == `SUB_ENTRY) begin
      subWord = {1'b1, entry};
    end else begin
      subWord = 33'h000000000;
    end
  endfunction

  wire logic                 mbxTake;
  wire logic                 pdoTake;
  wire logic                 inMbx;
  wire logic                 inPdo;
  wire logic                 isOp;
  wire logic                 cfgOpen;
  wire logic                 linkCodeOk;
  wire logic                 wdogTrip;
  wire logic                 modeWr;
  wire logic                 patWr;
  wire logic                 facWr;
  wire logic                 wrOk;
  wire logic                 rdOk;
  wire logic [31:0]          rdData;
  wire logic [31:0]          statusNow;
  wire logic [OUT_COUNT-1:0] fallback;

  assign mbxTake = mbxReqValid && !mbxPend_q;
  assign pdoTake = pdoReqValid && !pdoPend_q;
  assign inMbx   = arbState_q == ARB_MBX;
  assign inPdo   = arbState_q == ARB_PDO;
  assign isOp    = linkState_q == `LINK_OP;
  assign cfgOpen = linkState_q == `LINK_PREOP;

  assign linkCodeOk = linkReqState == `LINK_INIT || linkReqState == `LINK_PREOP ||
                      linkReqState == `LINK_BOOT || linkReqState == `LINK_SAFEOP ||
                      linkReqState == `LINK_OP;
  assign wdogTrip = isOp && wdogCnt_q == WDOG_W'(WDOG_CYCLES - 1);

  // fallback mode and pattern objects accept values only while pre-operational; the factory object in any state
  assign modeWr = mbxIdx_q == `OBJ_FB_MODE && mbxSub_q == `SUB_COUNT && cfgOpen &&
                  mbxData_q[31:8] == 24'h000000 && mbxData_q[7:0] <= `FB_PATTERN;
  assign patWr  = mbxIdx_q == `OBJ_FB_PATTERN && mbxSub_q == `SUB_ENTRY && cfgOpen &&
                  mbxData_q[31:8] == 24'h000000;
  assign facWr  = mbxIdx_q == `OBJ_FACTORY && mbxSub_q == `SUB_COUNT &&
                  mbxData_q[31:1] == 31'h00000000;
  assign wrOk   = modeWr || patWr || facWr;

  assign statusNow = {26'h0000000, sensorUnderVolt, sensorSurge, actuatorUnderVolt,
                      actuatorShort, outputSurge, outputShort};

  always_comb begin
    if (mbxIdx_q == `OBJ_OUT_MAP) begin
      rdResult = subWord(mbxSub_q, `ENTRIES_TWO, {`OBJ_OUT_BYTE, `SUB_ENTRY, `MAP_LEN_BYTE});
    end else if (mbxIdx_q == `OBJ_IN_MAP) begin
      rdResult = subWord(mbxSub_q, `ENTRIES_TWO, {`OBJ_IN_BYTE, `SUB_ENTRY, `MAP_LEN_BYTE});
    end else if (mbxIdx_q == `OBJ_STAT_MAP) begin
      rdResult = subWord(mbxSub_q, `ENTRIES_ONE, {`OBJ_DIAG_WORD, `SUB_ENTRY, `MAP_LEN_WORD});
    end else if (mbxIdx_q == `OBJ_FB_MODE && mbxSub_q == `SUB_COUNT) begin
      rdResult = {1'b1, 24'h000000, fbMode_q};
    end else if (mbxIdx_q == `OBJ_FB_PATTERN) begin
      rdResult = subWord(mbxSub_q, `ENTRIES_ONE, {24'h000000, fbPat_q});
    end else if (mbxIdx_q == `OBJ_FACTORY && mbxSub_q == `SUB_COUNT) begin
      rdResult = {1'b1, 24'h000000, facReq_q};
    end else if (mbxIdx_q == `OBJ_IN_BYTE) begin
      rdResult = subWord(mbxSub_q, `ENTRIES_TWO, {24'h000000, inImage_q});
    end else if (mbxIdx_q == `OBJ_DIAG_WORD) begin
      rdResult = subWord(mbxSub_q, `ENTRIES_ONE, statImage_q);
    end else if (mbxIdx_q == `OBJ_OUT_BYTE) begin
      rdResult = subWord(mbxSub_q, `ENTRIES_TWO, {24'h000000, 8'(outImage_q)});
    end else begin
      rdResult = 33'h000000000;
    end
  end

  assign rdOk   = rdResult[32];
  assign rdData = rdResult[31:0];

  // mailbox first; cyclic exchange only when no mailbox work waits
  always_comb begin
    arbState_d = ARB_IDLE;
    case (arbState_q)
      ARB_IDLE: begin
        if (mbxPend_q) begin
          arbState_d = ARB_MBX;
        end else if (pdoPend_q) begin
          arbState_d = ARB_PDO;
        end
      end
      default: arbState_d = ARB_IDLE;
    endcase
  end

  output_fallback_select #(
    .OUT_COUNT (OUT_COUNT)
  ) u_fallback (
    .mode     (fbMode_q),
    .pattern  (fbPat_q),
    .lastOut  (digitalOut_q),
    .fallback (fallback)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      arbState_q <= ARB_IDLE;
    end else begin
      arbState_q <= arbState_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mbxPend_q <= 1'b0;
      mbxWr_q   <= 1'b0;
      mbxIdx_q  <= 16'h0000;
      mbxSub_q  <= 8'h00;
      mbxData_q <= 32'h00000000;
    end else if (mbxTake) begin
      mbxPend_q <= 1'b1;
      mbxWr_q   <= mbxReqWrite;
      mbxIdx_q  <= mbxIndex;
      mbxSub_q  <= mbxSubindex;
      mbxData_q <= mbxWrData;
    end else if (inMbx) begin
      mbxPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pdoPend_q <= 1'b0;
      pdoData_q <= 8'h00;
    end else if (pdoTake) begin
      pdoPend_q <= 1'b1;
      pdoData_q <= pdoOutData;
    end else if (inPdo) begin
      pdoPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mbxAck_q    <= 1'b0;
      mbxAbort_q  <= 1'b0;
      mbxRdData_q <= 32'h00000000;
    end else begin
      mbxAck_q    <= inMbx;
      mbxAbort_q  <= inMbx && (mbxWr_q ? !wrOk : !rdOk);
      mbxRdData_q <= (inMbx && !mbxWr_q && rdOk) ? rdData : 32'h00000000;
    end
  end

  // restart wins over a mailbox write landing in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      fbMode_q         <= `FB_MODE_RESET;
      fbPat_q          <= `FB_PATTERN_RESET;
      facReq_q         <= `FACTORY_NORMAL;
      factoryApplied_q <= 1'b0;
    end else if (deviceRestart) begin
      factoryApplied_q <= facReq_q == `FACTORY_RESTORE;
      if (facReq_q == `FACTORY_RESTORE) begin
        fbMode_q <= `FB_MODE_RESET;
        fbPat_q  <= `FB_PATTERN_RESET;
        facReq_q <= `FACTORY_NORMAL;
      end
    end else begin
      factoryApplied_q <= 1'b0;
      if (inMbx && mbxWr_q && modeWr) begin
        fbMode_q <= mbxData_q[7:0];
      end
      if (inMbx && mbxWr_q && patWr) begin
        fbPat_q <= mbxData_q[7:0];
      end
      if (inMbx && mbxWr_q && facWr) begin
        facReq_q <= mbxData_q[7:0];
      end
    end
  end

  // snapshot of both directions in one cycle keeps the image coherent
  always_ff @(posedge clk) begin
    if (rst) begin
      outImage_q      <= '0;
      inImage_q       <= 8'h00;
      statImage_q     <= 32'h00000000;
      pdoDone_q       <= 1'b0;
      pdoInByte_q     <= 8'h00;
      pdoStatusWord_q <= 32'h00000000;
    end else begin
      pdoDone_q <= inPdo;
      if (inPdo) begin
        outImage_q      <= pdoData_q[OUT_COUNT-1:0];
        inImage_q       <= digitalIn;
        statImage_q     <= statusNow;
        pdoInByte_q     <= digitalIn;
        pdoStatusWord_q <= statusNow;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wdogCnt_q <= '0;
    end else if (!isOp || inPdo || wdogTrip) begin
      wdogCnt_q <= '0;
    end else begin
      wdogCnt_q <= wdogCnt_q + WDOG_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      linkState_q    <= `LINK_INIT;
      linkReqError_q <= 1'b0;
      commFault_q    <= 1'b0;
    end else begin
      linkReqError_q <= linkReqValid && !linkCodeOk;
      if (deviceRestart) begin
        linkState_q <= `LINK_INIT;
      end else if (wdogTrip) begin
        linkState_q <= `LINK_SAFEOP;
      end else if (linkReqValid && linkCodeOk) begin
        linkState_q <= linkReqState;
      end
      // a new trip beats the clear from a state request
      if (wdogTrip) begin
        commFault_q <= 1'b1;
      end else if (linkReqValid && linkCodeOk) begin
        commFault_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      digitalOut_q <= '0;
    end else begin
      digitalOut_q <= isOp ? outImage_q : fallback;
    end
  end

  assign mbxBusy        = mbxPend_q;
  assign mbxAck         = mbxAck_q;
  assign mbxAbort       = mbxAbort_q;
  assign mbxRdData      = mbxRdData_q;
  assign pdoBusy        = pdoPend_q;
  assign pdoDone        = pdoDone_q;
  assign pdoInByte      = pdoInByte_q;
  assign pdoStatusWord  = pdoStatusWord_q;
  assign linkState      = linkState_q;
  assign linkReqError   = linkReqError_q;
  assign commFault      = commFault_q;
  assign factoryApplied = factoryApplied_q;
  assign digitalOut     = digitalOut_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_both_waiting;
    arbState_q == ARB_IDLE && mbxPend_q && pdoPend_q;
  endsequence

  sequence s_mbx_then_pdo;
    arbState_q == ARB_MBX ##1 arbState_q == ARB_IDLE ##1 arbState_q == ARB_PDO;
  endsequence

  sequence s_restore_requested;
    inMbx && mbxWr_q && facWr && mbxData_q[7:0] == `FACTORY_RESTORE && !deviceRestart;
  endsequence

  a_mailbox_first: assert property (s_both_waiting |=> s_mbx_then_pdo)
    else $error("cyclic exchange overtook a pending mailbox request");

  a_safe_low_out: assert property (!isOp && fbMode_q == `FB_LOW |=> digitalOut_q == '0)
    else $error("mode low did not clear outputs");

  a_safe_high_out: assert property (!isOp && fbMode_q == `FB_HIGH |=> digitalOut_q == '1)
    else $error("mode high did not set outputs");

  a_hold_last_out: assert property (!isOp && fbMode_q == `FB_HOLD |=> $stable(digitalOut_q))
    else $error("mode hold changed outputs");

  a_pattern_out: assert property (!isOp && fbMode_q == `FB_PATTERN
                                  |=> digitalOut_q == $past(fbPat_q[OUT_COUNT-1:0]))
    else $error("substitute pattern not driven");

  a_op_cyclic_out: assert property (isOp ##1 isOp |=> digitalOut_q == $past(outImage_q))
    else $error("operational outputs not from cyclic data");

  a_cfg_locked: assert property (inMbx && mbxWr_q && !cfgOpen && mbxIdx_q == `OBJ_FB_MODE
                                 && !deviceRestart |=> $stable(fbMode_q) && mbxAbort_q)
    else $error("mode changed outside pre-operational");

  a_restore_deferred: assert property (s_restore_requested |=>
                                       facReq_q == `FACTORY_RESTORE && $stable(fbMode_q))
    else $error("factory restore acted before restart");

  a_restart_applies: assert property (deviceRestart && facReq_q == `FACTORY_RESTORE |=>
                                      fbMode_q == `FB_MODE_RESET && factoryApplied_q ##1 !factoryApplied_q)
    else $error("restart did not apply factory settings");

  a_wdog_trips: assert property (wdogTrip && !deviceRestart |=>
                                 linkState_q == `LINK_SAFEOP && commFault_q)
    else $error("watchdog expiry did not leave operational");

  a_status_upper: assert property (pdoDone_q |-> pdoStatusWord_q[31:6] == 26'h0000000)
    else $error("reserved status bits set");
endmodule

// ### fieldbus_master_model.sv
// fieldbus master model issuing cyclic exchanges one at a time
`timescale 1ns/1ps
module fieldbus_master_model (
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [3:0] gap,
  input  wire logic [7:0] nextData,
  input  wire logic       pdoBusy,
  input  wire logic       pdoDone,
  output logic            pdoReqValid,
  output logic [7:0]      pdoOutData,
  output logic [7:0]      sentData
);
  int w;
  initial begin
    pdoReqValid = 1'b0;
    pdoOutData  = 8'h00;
    sentData    = 8'h00;
    forever begin
      @(negedge clk);
      if (en && pdoBusy === 1'b0) begin
        repeat (gap) @(negedge clk);
        pdoReqValid = 1'b1;
        pdoOutData  = nextData;
        @(negedge clk);
        sentData    = pdoOutData;
        pdoReqValid = 1'b0;
        // released data must not look like a held value
        pdoOutData  = ~pdoOutData;
        w = 0;
        while (pdoDone !== 1'b1 && w < 12) begin
          @(negedge clk);
          w++;
        end
      end
    end
  end
endmodule

// ### tb.sv
// self-checking bench for the fieldbus i/o image block
`timescale 1ns/1ps
`include "fieldbus_io_defs.svh"
module tb;
  typedef struct {logic [31:0] data; logic abort;} mbxNote_t;
  logic        clk, rst, mbxReqValid, mbxReqWrite, mbxBusy, mbxAck, mbxAbort;
  logic [15:0] mbxIndex;
  logic [7:0]  mbxSubindex, pdoOutData, pdoInByte, digitalIn, nextData, sentData, pat;
  logic [31:0] mbxWrData, mbxRdData, pdoStatusWord, r, seed;
  logic        pdoReqValid, pdoBusy, pdoDone, linkReqValid, linkReqError, commFault;
  logic        deviceRestart, factoryApplied, en;
  logic [3:0]  linkReqState, linkState, digitalOut, gap;
  logic [5:0]  diag;
  int          errors, compares, cycles;
  mbxNote_t    notes[$];
  logic [15:0] tIdx [9] = '{`OBJ_OUT_MAP, `OBJ_IN_MAP, `OBJ_STAT_MAP, `OBJ_OUT_MAP, `OBJ_IN_MAP,
                            `OBJ_STAT_MAP, `OBJ_FB_MODE, `OBJ_FACTORY, `OBJ_FB_PATTERN};
  logic [7:0]  tSub [9] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [31:0] tVal [9] = '{32'h50000108, 32'h40000108, 32'h40010120, 32'h00000002, 32'h00000002,
                            32'h00000001, 32'h00000000, 32'h00000000, 32'h00000001};
  logic [7:0]  modes [4] = '{8'h00, 8'h01, 8'h03, 8'h02};

  fieldbus_io_safe_state_image #(.OUT_COUNT(4), .WDOG_CYCLES(20)) i_fieldbus_io_safe_state_image (
    .clk(clk), .rst(rst), .mbxReqValid(mbxReqValid), .mbxReqWrite(mbxReqWrite), .mbxIndex(mbxIndex),
    .mbxSubindex(mbxSubindex), .mbxWrData(mbxWrData), .mbxBusy(mbxBusy), .mbxAck(mbxAck),
    .mbxAbort(mbxAbort), .mbxRdData(mbxRdData), .pdoReqValid(pdoReqValid), .pdoOutData(pdoOutData),
    .pdoBusy(pdoBusy), .pdoDone(pdoDone), .pdoInByte(pdoInByte), .pdoStatusWord(pdoStatusWord),
    .linkReqValid(linkReqValid), .linkReqState(linkReqState), .linkState(linkState),
    .linkReqError(linkReqError), .commFault(commFault), .deviceRestart(deviceRestart),
    .factoryApplied(factoryApplied), .digitalIn(digitalIn), .sensorUnderVolt(diag[5]),
    .sensorSurge(diag[4]), .actuatorUnderVolt(diag[3]), .actuatorShort(diag[2]),
    .outputSurge(diag[1]), .outputShort(diag[0]), .digitalOut(digitalOut));

  fieldbus_master_model i_fieldbus_master_model (
    .clk(clk), .en(en), .gap(gap), .nextData(nextData), .pdoBusy(pdoBusy), .pdoDone(pdoDone),
    .pdoReqValid(pdoReqValid), .pdoOutData(pdoOutData), .sentData(sentData));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // entered at a falling edge; one request outstanding at a time
  task automatic mbx(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic [31:0] exp, input logic ab);
    int w;
    mbxNote_t n;
    n.data = exp;
    n.abort = ab;
    notes.push_back(n);
    mbxReqValid = 1'b1;
    mbxReqWrite = wr;
    mbxIndex = idx;
    mbxSubindex = sub;
    mbxWrData = wd;
    @(negedge clk);
    check(32'(mbxBusy), 32'h00000001);
    mbxReqValid = 1'b0;
    mbxWrData = ~wd;
    w = 1;
    while (mbxAck !== 1'b1 && w < 4) begin
      @(negedge clk);
      w++;
    end
    check(32'(mbxAck), 32'h00000001);
    @(negedge clk);
  endtask

  task automatic setLink(input logic [3:0] s);
    linkReqValid = 1'b1;
    linkReqState = s;
    @(negedge clk);
    linkReqValid = 1'b0;
    linkReqState = ~s;
  endtask

  always @(negedge clk) begin
    if (mbxAck === 1'b1) begin
      if (notes.size() == 0) check(32'h00000001, 32'h00000000);
      else begin
        check(mbxRdData, notes[0].data);
        check(32'(mbxAbort), 32'(notes[0].abort));
        void'(notes.pop_front());
      end
    end
    if (pdoDone === 1'b1) begin
      check(32'(pdoInByte), 32'(digitalIn));
      check(32'(pdoBusy), 32'h00000000);
      check(pdoStatusWord, {26'h0000000, diag});
    end
    r = rnd();
    nextData = r[7:0];
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // limit leaves ample margin over the roughly 210 cycles of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    seed = 32'h0000004D;
    rst = 1'b1;
    {mbxReqValid, mbxReqWrite, linkReqValid, deviceRestart, en} = 5'h00;
    mbxIndex = 16'h0000;
    mbxSubindex = 8'h00;
    mbxWrData = 32'h00000000;
    linkReqState = 4'h0;
    gap = 4'h0;
    r = rnd();
    digitalIn = r[7:0];
    diag = r[13:8];
    pat = r[23:16];
    nextData = 8'h00;
    cyc(16);
    rst = 1'b0;
    cyc(1);
    check(32'(linkState), 32'(`LINK_INIT));
    check(32'(digitalOut), 32'h00000000);
    for (int i = 0; i < 9; i++) mbx(1'b0, tIdx[i], tSub[i], 32'h0, tVal[i], 1'b0);
    mbx(1'b1, `OBJ_FB_MODE, `SUB_COUNT, 32'h00000003, 32'h0, 1'b1);
    mbx(1'b1, `OBJ_IN_BYTE, `SUB_ENTRY, 32'h00000001, 32'h0, 1'b1);
    mbx(1'b0, 16'h3000, `SUB_COUNT, 32'h0, 32'h0, 1'b1);
    setLink(4'h5);
    check(32'(linkReqError), 32'h00000001);
    setLink(`LINK_PREOP);
    check(32'(linkState), 32'(`LINK_PREOP));
    // master configures the fallback only while pre-operational
    mbx(1'b1, `OBJ_FB_PATTERN, `SUB_ENTRY, 32'(pat), 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      mbx(1'b1, `OBJ_FB_MODE, `SUB_COUNT, 32'(modes[i]), 32'h0, 1'b0);
      cyc(2);
      check(32'(digitalOut), i == 0 ? 32'h0 : i == 1 ? 32'hF : 32'(pat[3:0]));
    end
    mbx(1'b1, `OBJ_FB_MODE, `SUB_COUNT, 32'h00000004, 32'h0, 1'b1);
    mbx(1'b1, `OBJ_FB_MODE, `SUB_COUNT, 32'h00000003, 32'h0, 1'b0);
    gap = r[27:24] & 4'h3;
    en = 1'b1;
    setLink(`LINK_OP);
    cyc(30);
    mbx(1'b0, `OBJ_STAT_MAP, `SUB_COUNT, 32'h0, 32'h00000001, 1'b0);
    en = 1'b0;
    cyc(14);
    check(32'(linkState), 32'(`LINK_OP));
    check(32'(digitalOut), 32'(sentData[3:0]));
    cyc(30);
    check(32'(linkState), 32'(`LINK_SAFEOP));
    check(32'(commFault), 32'h00000001);
    check(32'(digitalOut), 32'(pat[3:0]));
    mbx(1'b1, `OBJ_FB_MODE, `SUB_COUNT, 32'h00000001, 32'h0, 1'b1);
    mbx(1'b1, `OBJ_FACTORY, `SUB_COUNT, 32'h00000002, 32'h0, 1'b1);
    mbx(1'b1, `OBJ_FACTORY, `SUB_COUNT, 32'h00000001, 32'h0, 1'b0);
    mbx(1'b0, `OBJ_FACTORY, `SUB_COUNT, 32'h0, 32'h00000001, 1'b0);
    mbx(1'b0, `OBJ_FB_MODE, `SUB_COUNT, 32'h0, 32'h00000003, 1'b0);
    deviceRestart = 1'b1;
    cyc(1);
    deviceRestart = 1'b0;
    check(32'(factoryApplied), 32'h00000001);
    check(32'(linkState), 32'(`LINK_INIT));
    mbx(1'b0, `OBJ_FB_MODE, `SUB_COUNT, 32'h0, 32'h00000000, 1'b0);
    mbx(1'b0, `OBJ_FACTORY, `SUB_COUNT, 32'h0, 32'h00000000, 1'b0);
    cyc(2);
    end_sim();
  end
endmodule
